// >>> asb_pkg.sv
// Purpose: shared constants and types for the serial status and baud block
// Assumes: byte-wide register port, one 100 MHz clock
// Notes:   offsets are byte addresses on the plain register port
package asb_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ASB_OFS_BAUD = 8'h2B;
  localparam logic [7:0] ASB_OFS_CTRL = 8'h2D;
  localparam logic [7:0] ASB_OFS_STAT = 8'h2E;
  localparam logic [7:0] ASB_OFS_DATA = 8'h2F;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         ASB_BAUD_DIVIDER_CLEAR_TEST_BIT = 7;
  localparam int         ASB_BAUD_SCP_LSB  = 4;
  localparam int         ASB_BAUD_DIVIDER_CLOCK_CHECK_TEST_BIT = 3;
  localparam int         ASB_BAUD_SCR_LSB  = 0;
  localparam logic [1:0] ASB_SCP_RESET     = 2'h0;
  localparam logic [7:0] ASB_CTRL_RESET    = 8'h00;
  localparam logic [7:0] ASB_STAT_RESET    = 8'hC0;

  // ----------------------------------------------------------------
  // divider counts
  // ----------------------------------------------------------------
  localparam logic [3:0] ASB_PRE_DIV1  = 4'h1;
  localparam logic [3:0] ASB_PRE_DIV3  = 4'h3;
  localparam logic [3:0] ASB_PRE_DIV4  = 4'h4;
  localparam logic [3:0] ASB_PRE_DIV13 = 4'hD;
  localparam logic [3:0] ASB_RT_PER_BIT_M1 = 4'hF;
  localparam logic [3:0] ASB_CHAR_BITS     = 4'hA;

  // ----------------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tx_empty_flag;
    logic tx_complete_flag;
    logic rx_full_flag;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_error_flag;
    logic zero;
  } asb_status_t;

  typedef struct packed {
    logic tx_empty_int_enable;
    logic tx_complete_int_enable;
    logic rx_int_enable;
    logic line_idle_int_enable;
    logic transmitter_enable_bit;
    logic rx_enable;
    logic rx_sleep_control;
    logic send_break;
  } asb_ctrl_t;

endpackage

// >>> asb_serial_status.sv
// Purpose: receive/transmit status flags, baud rate chain and request logic
// Assumes: shift and framing engines sit outside and report by pulses
// Notes:   serial line input is synchronised; engine inputs share clk_in
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - character moved into the holding buffer sets the receive-full flag
// - receive flags clear by status read seeing them, then data register read
// - idle flag sets again only after line was active then idle
// - idle flag never sets while the sleep control bit is one
// - line counts idle after one full character time of continuous ones
// - character arriving while full sets overrun, dropped, buffer kept
// - noise flag sets when any majority vote is not unanimous
// - framing flag sets when stop bit position samples zero
// - noise and framing flags never drive the interrupt request
// - baud register holds 2-bit prescale and 3-bit rate fields in series
// - prescale codes divide the clock by 1, 3, 4 or 13
// - rate divider divides prescaler output by two to the rate code
// - divider output is 16x sampling tick; bit tick is that over 16
// - reset sets fastest prescale; software may rewrite it anytime
// - reset keeps rate bits; software should not change them mid-transfer
// - enabling the transmitter sets transmit-empty and transmit-complete
// - transmit-empty with its enable requests an interrupt
// - transmit-complete with its enable requests an interrupt
// - disabling mid-character finishes it and drops queued data
// - disabling while idle frees the pin on the next bit tick
// - last character done sets both transmit flags even when disabled
// - receive enable routes receive-full or overrun to the request
// - idle enable routes the idle flag to the request
// - transmit flags clear by status read seeing them, then data write
module asb_serial_status
  import asb_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       rx_line_in,
  input  wire logic       rx_vote_valid_in,
  input  wire logic [2:0] rx_votes_in,
  input  wire logic       rx_char_done_in,
  input  wire logic [7:0] rx_char_in,
  input  wire logic       rx_stop_bit_in,
  input  wire logic       tx_take_in,
  input  wire logic       tx_busy_in,
  input  wire logic       tx_char_done_in,
  output logic      [7:0] tx_data_out,
  output logic            tx_data_valid_out,
  output logic            tx_pin_owned_out,
  output logic            rx_sample_clock_out,
  output logic            bit_clock_out,
  output logic            irq_out
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  asb_status_t stat_q;
  asb_ctrl_t   ctrl_q;
  logic [1:0]  prescale_select_q;
  logic [2:0]  rate_divide_select_q;
  logic        divider_clear_test_q;
  logic        divider_clock_check_test_q;
  logic [7:0]  rx_holding_buffer_q;
  logic [7:0]  tx_holding_buffer_q;
  logic [7:0]  arm_q;
  logic [7:0]  rdata_q;

  logic baud_wr;
  logic ctrl_wr;
  logic stat_rd;
  logic data_rd;
  logic data_wr;

  assign baud_wr = reg_wr_in && (reg_addr_in == ASB_OFS_BAUD);
  assign ctrl_wr = reg_wr_in && (reg_addr_in == ASB_OFS_CTRL);
  assign stat_rd = reg_rd_in && (reg_addr_in == ASB_OFS_STAT);
  assign data_rd = reg_rd_in && (reg_addr_in == ASB_OFS_DATA);
  assign data_wr = reg_wr_in && (reg_addr_in == ASB_OFS_DATA);

  // ----------------------------------------------------------------
  // baud register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      prescale_select_q          <= ASB_SCP_RESET;
      divider_clear_test_q       <= 1'b0;
      divider_clock_check_test_q <= 1'b0;
    end
    else if (baud_wr)
    begin
      prescale_select_q          <= reg_wdata_in[ASB_BAUD_SCP_LSB +: 2];
      divider_clear_test_q       <= reg_wdata_in[ASB_BAUD_DIVIDER_CLEAR_TEST_BIT];
      divider_clock_check_test_q <= reg_wdata_in[ASB_BAUD_DIVIDER_CLOCK_CHECK_TEST_BIT];
    end

  // rate bits hold their value through reset
  always_ff @(posedge clk_in)
    if (baud_wr)
      rate_divide_select_q <= reg_wdata_in[ASB_BAUD_SCR_LSB +: 3];

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      ctrl_q <= asb_ctrl_t'(ASB_CTRL_RESET);
    else if (ctrl_wr)
      ctrl_q <= asb_ctrl_t'(reg_wdata_in);

  // ----------------------------------------------------------------
  // baud chain
  // ----------------------------------------------------------------
  logic [3:0] pre_cnt_q;
  logic [3:0] pre_div;
  logic       pre_en;
  logic [6:0] rate_cnt_q;
  logic [6:0] rate_mask;
  logic       rt_en;
  logic [3:0] rt_cnt_q;
  logic       bit_en;

  always_comb
    case (prescale_select_q)
      2'h0:    pre_div = ASB_PRE_DIV1;
      2'h1:    pre_div = ASB_PRE_DIV3;
      2'h2:    pre_div = ASB_PRE_DIV4;
      default: pre_div = ASB_PRE_DIV13;
    endcase

  assign pre_en    = !divider_clear_test_q && (pre_cnt_q >= pre_div - 4'h1);
  assign rate_mask = 7'((8'h01 << rate_divide_select_q) - 8'h01);
  assign rt_en     = pre_en && ((rate_cnt_q & rate_mask) == rate_mask);
  assign bit_en    = rt_en && (rt_cnt_q == ASB_RT_PER_BIT_M1);

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      pre_cnt_q <= 4'h0;
    else if (divider_clear_test_q || pre_en)
      pre_cnt_q <= 4'h0;
    else
      pre_cnt_q <= pre_cnt_q + 4'h1;

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      rate_cnt_q <= 7'h00;
    else if (divider_clear_test_q)
      rate_cnt_q <= 7'h00;
    else if (pre_en)
      rate_cnt_q <= rate_cnt_q + 7'h01;

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      rt_cnt_q <= 4'h0;
    else if (divider_clear_test_q)
      rt_cnt_q <= 4'h0;
    else if (rt_en)
      rt_cnt_q <= rt_cnt_q + 4'h1;

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      rx_sample_clock_out <= 1'b0;
      bit_clock_out       <= 1'b0;
    end
    else
    begin
      rx_sample_clock_out <= rt_en;
      bit_clock_out       <= bit_en;
    end

  // ----------------------------------------------------------------
  // receive line idle detection
  // ----------------------------------------------------------------
  logic       line_s1_q;
  logic       line_s2_q;
  logic [3:0] idle_cnt_q;
  logic       line_active_q;
  logic       idle_set;

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
    end
    else
    begin
      line_s1_q <= rx_line_in;
      line_s2_q <= line_s1_q;
    end

  assign idle_set = line_active_q && bit_en && line_s2_q && (idle_cnt_q == ASB_CHAR_BITS - 4'h1);

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      idle_cnt_q <= 4'h0;
    else if (!line_s2_q)
      idle_cnt_q <= 4'h0;
    else if (bit_en && idle_cnt_q != ASB_CHAR_BITS - 4'h1)
      idle_cnt_q <= idle_cnt_q + 4'h1;

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      line_active_q <= 1'b0;
    else if (!line_s2_q)
      line_active_q <= 1'b1;
    else if (idle_set)
      line_active_q <= 1'b0;

  // ----------------------------------------------------------------
  // receive character capture
  // ----------------------------------------------------------------
  logic noise_acc_q;
  logic vote_split;

  assign vote_split = rx_vote_valid_in && (rx_votes_in != 3'h0) && (rx_votes_in != 3'h7);

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      noise_acc_q <= 1'b0;
    else if (rx_char_done_in)
      noise_acc_q <= 1'b0;
    else if (vote_split)
      noise_acc_q <= 1'b1;

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      rx_holding_buffer_q <= 8'h00;
    else if (rx_char_done_in && !stat_q.rx_full_flag)
      rx_holding_buffer_q <= rx_char_in;

  // ----------------------------------------------------------------
  // transmit queue
  // ----------------------------------------------------------------
  logic te_prev_q;
  logic te_rise;

  assign te_rise = ctrl_q.transmitter_enable_bit && !te_prev_q;

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      te_prev_q <= 1'b0;
    else
      te_prev_q <= ctrl_q.transmitter_enable_bit;

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      tx_holding_buffer_q <= 8'h00;
    else if (data_wr)
      tx_holding_buffer_q <= reg_wdata_in;

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      tx_data_valid_out <= 1'b0;
    else if (!ctrl_q.transmitter_enable_bit || tx_take_in)
      tx_data_valid_out <= 1'b0;
    else if (data_wr)
      tx_data_valid_out <= 1'b1;

  assign tx_data_out = tx_holding_buffer_q;

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      tx_pin_owned_out <= 1'b0;
    else if (ctrl_q.transmitter_enable_bit)
      tx_pin_owned_out <= 1'b1;
    else if (bit_en && !tx_busy_in)
      tx_pin_owned_out <= 1'b0;

  // ----------------------------------------------------------------
  // status flags, clear interlock
  // ----------------------------------------------------------------
  asb_status_t set_v;
  asb_status_t clr_v;

  always_comb
  begin
    set_v                    = '0;
    set_v.rx_full_flag       = rx_char_done_in && !stat_q.rx_full_flag;
    set_v.overrun_flag       = rx_char_done_in && stat_q.rx_full_flag;
    set_v.noise_flag         = set_v.rx_full_flag && (noise_acc_q || vote_split);
    set_v.framing_error_flag = set_v.rx_full_flag && !rx_stop_bit_in;
    set_v.idle_flag          = idle_set && !ctrl_q.rx_sleep_control;
    set_v.tx_empty_flag      = te_rise || tx_take_in || tx_char_done_in;
    set_v.tx_complete_flag   = te_rise || (tx_char_done_in && !tx_data_valid_out);
    clr_v                    = '0;
    clr_v[5:1]               = data_rd ? arm_q[5:1] : 5'h00;
    clr_v[7:6]               = data_wr ? arm_q[7:6] : 2'h0;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      arm_q <= 8'h00;
    else if (stat_rd)
      arm_q <= stat_q;
    else
      arm_q <= arm_q & ~clr_v;

  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      stat_q <= asb_status_t'(ASB_STAT_RESET);
    else
      stat_q <= (stat_q & ~clr_v) | set_v;

  // ----------------------------------------------------------------
  // read data and request
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
      rdata_q <= 8'h00;
    else if (reg_rd_in)
      case (reg_addr_in)
        ASB_OFS_BAUD: rdata_q <= {divider_clear_test_q, 1'b0, prescale_select_q,
                                  divider_clock_check_test_q, rate_divide_select_q};
        ASB_OFS_CTRL: rdata_q <= ctrl_q;
        ASB_OFS_STAT: rdata_q <= stat_q;
        ASB_OFS_DATA: rdata_q <= rx_holding_buffer_q;
        default:      rdata_q <= 8'h00;
      endcase
    else
      rdata_q <= 8'h00;

  assign reg_rdata_out = rdata_q;

  assign irq_out = (ctrl_q.tx_empty_int_enable && stat_q.tx_empty_flag)
                 || (ctrl_q.tx_complete_int_enable && stat_q.tx_complete_flag)
                 || (ctrl_q.rx_int_enable && (stat_q.rx_full_flag || stat_q.overrun_flag))
                 || (ctrl_q.line_idle_int_enable && stat_q.idle_flag);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_rx_arm;
    stat_rd && stat_q.rx_full_flag;
  endsequence

  sequence s_rx_take;
    data_rd && !rx_char_done_in;
  endsequence

  sequence s_pre4;
    pre_en && prescale_select_q == 2'h2 ##1 (prescale_select_q == 2'h2 && !divider_clear_test_q)[*4];
  endsequence

  a_rx_full_set: assert property (rx_char_done_in && !stat_q.rx_full_flag |=> stat_q.rx_full_flag)
    else $error("receive-full not set");
  a_rx_clear_seq: assert property (s_rx_arm ##1 s_rx_take |=> !stat_q.rx_full_flag)
    else $error("receive-full not cleared by sequence");
  a_rx_no_clear: assert property (data_rd && !arm_q[5] && stat_q.rx_full_flag |=> stat_q.rx_full_flag)
    else $error("receive-full cleared without status read");
  a_idle_sleep: assert property (ctrl_q.rx_sleep_control && !stat_q.idle_flag |=> !stat_q.idle_flag)
    else $error("idle set during sleep");
  a_overrun_keep: assert property (rx_char_done_in && stat_q.rx_full_flag
                                   |=> stat_q.overrun_flag && $stable(rx_holding_buffer_q))
    else $error("overrun handling wrong");
  a_noise_flag: assert property (vote_split && rx_char_done_in && !stat_q.rx_full_flag |=> stat_q.noise_flag)
    else $error("noise not flagged");
  a_frame_flag: assert property (rx_char_done_in && !stat_q.rx_full_flag && !rx_stop_bit_in
                                 |=> stat_q.framing_error_flag)
    else $error("framing not flagged");
  a_err_no_irq: assert property (ctrl_q == asb_ctrl_t'(8'h30) && !stat_q.rx_full_flag && !stat_q.overrun_flag
                                 && !stat_q.idle_flag |-> !irq_out)
    else $error("error flag raised request");
  a_pre_four: assert property (s_pre4 |-> pre_en)
    else $error("prescale by four period wrong");
  a_bit_tick: assert property (bit_en |-> rt_en && rt_cnt_q == 4'hF)
    else $error("bit tick not aligned to sampling tick");
  a_te_rise: assert property ($rose(ctrl_q.transmitter_enable_bit) |=> stat_q.tx_empty_flag
                              && stat_q.tx_complete_flag)
    else $error("enable did not set transmit flags");
  a_tx_irq: assert property (ctrl_q.tx_empty_int_enable && stat_q.tx_empty_flag |-> irq_out)
    else $error("transmit-empty request missing");
  a_pin_release: assert property (!ctrl_q.transmitter_enable_bit && tx_pin_owned_out && !(bit_en && !tx_busy_in)
                                  |=> tx_pin_owned_out)
    else $error("pin released off bit tick");

endmodule

`default_nettype wire

// >>> asb_line_model.sv
// Purpose: far-side model of receive line, receive framer and transmit shifter
// Assumes: bench clock; every change lands just after a rising edge
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module asb_line_model
  import asb_pkg::*;
(
  input  wire logic       clk_in,
  output logic            line_out,
  output logic            vote_ok_out,
  output logic      [2:0] votes_out,
  output logic            done_out,
  output logic      [7:0] char_out,
  output logic            stop_out,
  output logic            take_out,
  output logic            busy_out,
  output logic            tx_done_out
);
  initial
  begin
    line_out    = 1'b1;
    vote_ok_out = 1'b0;
    votes_out   = 3'h5;
    done_out    = 1'b0;
    char_out    = 8'hA5;
    stop_out    = 1'b0;
    take_out    = 1'b0;
    busy_out    = 1'b0;
    tx_done_out = 1'b0;
  end

  // one vote report, then a second one beside the finished character
  task automatic rx_char(input logic [7:0] c, input logic noisy, input logic stop);
    @(posedge clk_in);
    vote_ok_out <= 1'b1;
    votes_out   <= noisy ? 3'h2 : 3'h7;
    @(posedge clk_in);
    votes_out   <= noisy ? 3'h5 : 3'h0;
    done_out    <= 1'b1;
    char_out    <= c;
    stop_out    <= stop;
    @(posedge clk_in);
    vote_ok_out <= 1'b0;
    votes_out   <= ~votes_out;
    done_out    <= 1'b0;
    char_out    <= ~c;
    stop_out    <= ~stop;
  endtask

  // line active for a short while, then back to idle
  task automatic line_blip();
    @(posedge clk_in);
    line_out <= 1'b0;
    repeat (20) @(posedge clk_in);
    line_out <= 1'b1;
  endtask

  // take starts a character, otherwise the character ends
  task automatic tx_event(input logic take);
    @(posedge clk_in);
    take_out    <= take;
    tx_done_out <= !take;
    busy_out    <= take;
    @(posedge clk_in);
    take_out    <= 1'b0;
    tx_done_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Purpose: self-checking bench for the serial status and baud block
// Assumes: flag model in the bench, far side in asb_line_model
// Notes:   fastest baud is used except while timing the dividers
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import asb_pkg::*;
;
  logic       clk_in, rst_b_in, wr, rd, tx_valid, pin_owned, rt_tick, bit_tick, irq;
  logic [7:0] addr, wdata, rdata, tx_data, m_stat, m_arm, m_buf, m_ctrl;
  logic       line, vok, cdone, stopb, take, busy, tdone, m_valid;
  logic [2:0] votes;
  logic [7:0] ch;
  int         miscompares, n_compared, seed;
  int         pf[4] = '{1, 3, 4, 13};

  asb_serial_status DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .rx_line_in(line), .rx_vote_valid_in(vok), .rx_votes_in(votes), .rx_char_done_in(cdone),
    .rx_char_in(ch), .rx_stop_bit_in(stopb), .tx_take_in(take), .tx_busy_in(busy),
    .tx_char_done_in(tdone), .tx_data_out(tx_data), .tx_data_valid_out(tx_valid),
    .tx_pin_owned_out(pin_owned), .rx_sample_clock_out(rt_tick), .bit_clock_out(bit_tick),
    .irq_out(irq));
  asb_line_model PM (.clk_in(clk_in), .line_out(line), .vote_ok_out(vok), .votes_out(votes),
    .done_out(cdone), .char_out(ch), .stop_out(stopb), .take_out(take), .busy_out(busy),
    .tx_done_out(tdone));

  // ----------------------------------------------------------------
  // compare tasks and model
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_n(input string nm, input int e, input int g);
    n_compared++;
    if (g != e)
    begin
      miscompares++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  function automatic logic m_irq();
    return (m_ctrl[7] & m_stat[7]) | (m_ctrl[6] & m_stat[6]) | (m_ctrl[5] & (m_stat[5] | m_stat[3]))
      | (m_ctrl[4] & m_stat[4]);
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic reset_dut();
    rst_b_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    m_stat  = ASB_STAT_RESET;
    m_ctrl  = 8'h00;
    m_arm   = 8'h00;
    m_valid = 1'b0;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    if (a == ASB_OFS_DATA)
    begin
      m_stat  = m_stat & ~(m_arm & 8'hC0);
      m_valid = m_ctrl[3];
    end
    if (a == ASB_OFS_CTRL)
    begin
      if (v[3] && !m_ctrl[3])
        m_stat = m_stat | 8'hC0;
      if (!v[3])
        m_valid = 1'b0;
      m_ctrl = v;
    end
    #1;
    chk8("irq", {7'h00, m_irq()}, {7'h00, irq});
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] mask);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk8("read data", e, rdata & mask);
    if (a == ASB_OFS_STAT)
      m_arm = m_stat;
    if (a == ASB_OFS_DATA)
      m_stat = m_stat & ~(m_arm & 8'h3E);
  endtask
  // status read directly followed by a data read, no idle cycle between
  task automatic rd_pair(input logic [7:0] es, input logic [7:0] ed);
    @(posedge clk_in);
    addr <= ASB_OFS_STAT;
    rd   <= 1'b1;
    @(posedge clk_in);
    addr <= ASB_OFS_DATA;
    #1;
    chk8("read data", es, rdata);
    m_arm = m_stat;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk8("read data", ed, rdata);
    m_stat = m_stat & ~(m_arm & 8'h3E);
  endtask
  task automatic rxc(input logic [7:0] c, input logic noisy, input logic stop);
    PM.rx_char(c, noisy, stop);
    if (m_stat[5])
      m_stat[3] = 1'b1;
    else
    begin
      m_stat[5] = 1'b1;
      m_stat[2] = noisy;
      m_stat[1] = !stop;
      m_buf     = c;
    end
  endtask
  task automatic tx_ev(input logic t);
    PM.tx_event(t);
    m_stat[7] = 1'b1;
    if (t)
      m_valid = 1'b0;
    else if (!m_valid)
      m_stat[6] = 1'b1;
    #1;
    chk8("irq", {7'h00, m_irq()}, {7'h00, irq});
  endtask
  function automatic logic tick(input int b);
    return ((b != 0) ? bit_tick : rt_tick) === 1'b1;
  endfunction
  task automatic gap(input int b, output int n);
    int k;
    k = 0;
    while (!tick(b) && k < 5000)
    begin
      @(posedge clk_in);
      #1;
      k++;
    end
    n = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      n++;
    end while (!tick(b) && n < 5000);
  endtask
  task automatic measure(input int p, input int r);
    int n;
    reg_wr(ASB_OFS_BAUD, 8'(p * 16 + r));
    for (int b = 0; b < 2; b++)
    begin
      gap(b, n);
      gap(b, n);
      chk_n("tick gap", (pf[p] << r) * (b ? 16 : 1), n);
    end
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial
  begin
    #400000;
    miscompares++;
    stop_test();
  end
  initial
  begin
    rst_b_in = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    seed = 84;
    miscompares = 0;
    n_compared = 0;
    m_buf = 8'h00;
    reset_dut();
    reg_rd(ASB_OFS_BAUD, 8'h00, 8'hF8);
    reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
    reg_wr(8'h00, 8'h5A);
    reg_rd(8'h00, 8'h00, 8'hFF);
    reg_wr(ASB_OFS_STAT, 8'h00);
    reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
    for (int i = 0; i < 4; i++)
      measure(i, i);
    measure(0, 7);
    reg_wr(ASB_OFS_BAUD, 8'h35);
    reset_dut();
    reg_rd(ASB_OFS_BAUD, 8'h05, 8'hFF);
    reg_wr(ASB_OFS_BAUD, 8'h00);
    reg_wr(ASB_OFS_CTRL, 8'h30);
    for (int k = 0; k < 4; k++)
    begin
      rxc(8'($random(seed)), k[0], !k[1]);
      reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
      rxc(8'($random(seed)), 1'b0, 1'b1);
      if (k[1])
        rd_pair(m_stat, m_buf);
      else
      begin
        reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
        reg_rd(ASB_OFS_DATA, m_buf, 8'hFF);
      end
      reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
    end
    reg_wr(ASB_OFS_CTRL, 8'h10);
    PM.line_blip();
    step(120);
    reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
    step(100);
    m_stat[4] = 1'b1;
    reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
    reg_rd(ASB_OFS_DATA, m_buf, 8'hFF);
    step(300);
    reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
    reg_wr(ASB_OFS_CTRL, 8'h12);
    PM.line_blip();
    step(300);
    reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
    reg_wr(ASB_OFS_CTRL, 8'h10);
    PM.line_blip();
    step(300);
    m_stat[4] = 1'b1;
    reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
    reg_rd(ASB_OFS_DATA, m_buf, 8'hFF);
    reg_wr(ASB_OFS_CTRL, 8'h88);
    reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
    reg_wr(ASB_OFS_DATA, 8'h3C);
    chk8("tx data", 8'h3C, tx_data);
    chk8("tx valid", {7'h00, m_valid}, {7'h00, tx_valid});
    tx_ev(1'b1);
    chk8("tx valid", {7'h00, m_valid}, {7'h00, tx_valid});
    reg_wr(ASB_OFS_CTRL, 8'hC8);
    reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
    reg_wr(ASB_OFS_DATA, 8'($random(seed)));
    reg_wr(ASB_OFS_CTRL, 8'h40);
    step(1);
    chk8("tx valid", 8'h00, {7'h00, tx_valid});
    step(20);
    chk8("pin owned", 8'h01, {7'h00, pin_owned});
    tx_ev(1'b0);
    reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
    step(20);
    chk8("pin owned", 8'h00, {7'h00, pin_owned});
    reg_wr(ASB_OFS_DATA, 8'h81);
    reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
    reg_wr(ASB_OFS_CTRL, 8'h08);
    reg_rd(ASB_OFS_STAT, m_stat, 8'hFF);
    stop_test();
  end
endmodule
`default_nettype wire
